// ---- logic/tie_pkg.sv ----
// Constants and state type for the timer request-enable and compare-clear block.
package tie_pkg;

  localparam int NCH    = 5;
  localparam int NFLG   = 6;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register map, one byte per address.
  localparam logic [3:0] OFS_CLR_CTL = 4'h0;
  localparam logic [3:0] OFS_IEN0    = 4'h1;
  localparam logic [3:0] OFS_IEN_X   = 4'h6;
  localparam logic [3:0] OFS_IEN5    = 4'h7;
  localparam logic [3:0] OFS_STAT0   = 4'h8;
  localparam logic [3:0] OFS_STAT_X  = 4'hd;
  localparam logic [3:0] OFS_STAT5   = 4'he;

  // Bit positions inside the per-channel enable register.
  localparam int EN_A     = 0;
  localparam int EN_B     = 1;
  localparam int EN_C     = 2;
  localparam int EN_D     = 3;
  localparam int EN_OVF   = 4;
  localparam int EN_UNF   = 5;
  localparam int EN_TRGH  = 6;
  localparam int EN_TRGA  = 7;

  // Bit positions of the extra channel-0 enable register and its flags.
  localparam int EX_E     = 0;
  localparam int EX_F     = 1;
  localparam int EX_TRGE  = 7;

  // Channel-5 positions shared by clear control, enable and flags.
  localparam int C5_W     = 0;
  localparam int C5_V     = 1;
  localparam int C5_U     = 2;

  // Flag index inside the per-channel flag vector.
  localparam int FLG_A    = 0;
  localparam int FLG_B    = 1;
  localparam int FLG_C    = 2;
  localparam int FLG_D    = 3;
  localparam int FLG_OVF  = 4;
  localparam int FLG_UNF  = 5;

  // Writable bits; everything else is reserved and reads zero.
  localparam logic [NCH-1:0][DATA_W-1:0] IEN_WMASK = {8'hdf, 8'h9f, 8'hb3, 8'hb3, 8'h9f};
  localparam logic [DATA_W-1:0] IEN_X_WMASK = 8'h83;
  localparam logic [DATA_W-1:0] C5_WMASK    = 8'h07;

  // Flags that exist per channel (C, D in 0/3/4, underflow in 1/2).
  localparam logic [NCH-1:0][NFLG-1:0] FLG_VALID = {6'h1f, 6'h1f, 6'h33, 6'h33, 6'h1f};

  localparam int CH_OVF_TROUGH = 4;

  localparam logic [DATA_W-1:0] RST_BYTE = 8'h00;

  typedef struct packed {
    logic [DATA_W-1:0]              clr_ctl;
    logic [NCH-1:0][DATA_W-1:0]     ien;
    logic [DATA_W-1:0]              ien_x;
    logic [DATA_W-1:0]              ien5;
    logic [NCH-1:0][NFLG-1:0]       flg;
    logic [1:0]                     flg_x;
    logic [2:0]                     flg5;
    logic [DATA_W-1:0]              rdata;
  } tie_state_t;

endpackage : tie_pkg

// ---- logic/tie_timer_irq_enable.sv ----
// Request-enable and channel-5 compare-clear logic of a six-channel timer.
//
// Summary of operation
// - U enable clears counter U on event
// - V enable clears counter V on event
// - W enable clears counter W on event
// - Reserved enable bits read back zero
// - Bit 7 lets A event start ADC
// - Channel 4 bit 6: trough starts ADC
// - Bit 5 gates underflow request, channels 1-2
// - Bit 4 gates overflow request, all channels
// - Bit 3 gates D request, channels 0/3/4
// - Bit 2 gates C request, channels 0/3/4
// - Bit 1 gates B request, all channels
// - Bit 0 gates A request, all channels
// - Extra bit 7: E match starts ADC
// - Extra bit 1 gates F match request
// - Extra bit 0 gates E match request
// - Channel-5 bit 2 gates U request
// - Channel-5 bit 1 gates V request
// - Channel-5 bit 0 gates W request
// - Match or capture sets the A flag
// - Wrap, or channel-4 PWM trough, sets overflow flag
// - Phase-count underflow sets underflow flag
`timescale 1ns/100ps

module tie_timer_irq_enable (
  input  wire logic                                         clk_i,
  input  wire logic                                         rst_n_i,
  input  wire logic [tie_pkg::ADDR_W-1:0]                   reg_addr_i,
  input  wire logic [tie_pkg::DATA_W-1:0]                   reg_wdata_i,
  input  wire logic                                         reg_we_i,
  input  wire logic                                         reg_re_i,
  output logic      [tie_pkg::DATA_W-1:0]                   reg_rdata_o,
  input  wire logic [tie_pkg::NCH-1:0][3:0]                 cc_evt_i,
  input  wire logic [tie_pkg::NCH-1:0]                      wrap_evt_i,
  input  wire logic [tie_pkg::NCH-1:0]                      unf_evt_i,
  input  wire logic [tie_pkg::NCH-1:0]                      phase_cnt_i,
  input  wire logic                                         ch4_trough_i,
  input  wire logic                                         cpwm_mode_i,
  input  wire logic                                         ch0_cmp_e_evt_i,
  input  wire logic                                         ch0_cmp_f_evt_i,
  input  wire logic [2:0]                                   ch5_evt_i,
  input  wire logic [tie_pkg::NCH-1:0][tie_pkg::NFLG-1:0]   ch_flag_clr_i,
  input  wire logic [1:0]                                   x_flag_clr_i,
  input  wire logic [2:0]                                   ch5_flag_clr_i,
  output logic      [tie_pkg::NCH-1:0]                      cc_a_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      cc_b_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      cc_c_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      cc_d_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      overflow_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      underflow_irq_o,
  output logic                                              cmp_e_irq_o,
  output logic                                              cmp_f_irq_o,
  output logic                                              ch5_u_irq_o,
  output logic                                              ch5_v_irq_o,
  output logic                                              ch5_w_irq_o,
  output logic      [tie_pkg::NCH-1:0]                      adc_start_a_o,
  output logic                                              adc_start_trough_o,
  output logic                                              adc_start_e_o,
  output logic      [2:0]                                   ch5_clear_o
);

  tie_pkg::tie_state_t st;
  tie_pkg::tie_state_t next_st;
  logic [tie_pkg::NCH-1:0][tie_pkg::NFLG-1:0] flg_set;

  ////////////////////////////////////////////////////////////////////////////////
  // Flag set conditions from the counter core.

  always_comb begin
    for (int i = 0; i < tie_pkg::NCH; i++) begin
      flg_set[i][tie_pkg::FLG_A]   = cc_evt_i[i][tie_pkg::FLG_A];
      flg_set[i][tie_pkg::FLG_B]   = cc_evt_i[i][tie_pkg::FLG_B];
      flg_set[i][tie_pkg::FLG_C]   = cc_evt_i[i][tie_pkg::FLG_C];
      flg_set[i][tie_pkg::FLG_D]   = cc_evt_i[i][tie_pkg::FLG_D];
      flg_set[i][tie_pkg::FLG_OVF] = wrap_evt_i[i]
                                     | ((i == tie_pkg::CH_OVF_TROUGH) && ch4_trough_i && cpwm_mode_i);
      flg_set[i][tie_pkg::FLG_UNF] = unf_evt_i[i] & phase_cnt_i[i];
      flg_set[i] = flg_set[i] & tie_pkg::FLG_VALID[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic: register writes, sticky flags and read data.

  always_comb begin
    next_st = st;
    // A set in the same cycle as its clear wins, so no event is lost.
    for (int i = 0; i < tie_pkg::NCH; i++) begin
      next_st.flg[i] = flg_set[i] | (st.flg[i] & ~ch_flag_clr_i[i]);
    end
    next_st.flg_x[tie_pkg::EX_E] = ch0_cmp_e_evt_i | (st.flg_x[tie_pkg::EX_E] & ~x_flag_clr_i[tie_pkg::EX_E]);
    next_st.flg_x[tie_pkg::EX_F] = ch0_cmp_f_evt_i | (st.flg_x[tie_pkg::EX_F] & ~x_flag_clr_i[tie_pkg::EX_F]);
    next_st.flg5 = ch5_evt_i | (st.flg5 & ~ch5_flag_clr_i);

    if (reg_we_i) begin
      if (reg_addr_i == tie_pkg::OFS_CLR_CTL) begin
        next_st.clr_ctl = reg_wdata_i & tie_pkg::C5_WMASK;
      end
      for (int i = 0; i < tie_pkg::NCH; i++) begin
        if (reg_addr_i == tie_pkg::OFS_IEN0 + 4'(i)) begin
          next_st.ien[i] = reg_wdata_i & tie_pkg::IEN_WMASK[i];
        end
      end
      if (reg_addr_i == tie_pkg::OFS_IEN_X) begin
        next_st.ien_x = reg_wdata_i & tie_pkg::IEN_X_WMASK;
      end
      if (reg_addr_i == tie_pkg::OFS_IEN5) begin
        next_st.ien5 = reg_wdata_i & tie_pkg::C5_WMASK;
      end
    end

    // Read data stands only in the cycle after the read strobe.
    next_st.rdata = tie_pkg::RST_BYTE;
    if (reg_re_i) begin
      if (reg_addr_i == tie_pkg::OFS_CLR_CTL) begin
        next_st.rdata = st.clr_ctl;
      end
      if (reg_addr_i == tie_pkg::OFS_IEN_X) begin
        next_st.rdata = st.ien_x;
      end
      if (reg_addr_i == tie_pkg::OFS_IEN5) begin
        next_st.rdata = st.ien5;
      end
      if (reg_addr_i == tie_pkg::OFS_STAT_X) begin
        next_st.rdata = {6'h00, st.flg_x};
      end
      if (reg_addr_i == tie_pkg::OFS_STAT5) begin
        next_st.rdata = {5'h00, st.flg5};
      end
      for (int i = 0; i < tie_pkg::NCH; i++) begin
        if (reg_addr_i == tie_pkg::OFS_IEN0 + 4'(i)) begin
          next_st.rdata = st.ien[i];
        end
        if (reg_addr_i == tie_pkg::OFS_STAT0 + 4'(i)) begin
          next_st.rdata = {2'h0, st.flg[i]};
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Request outputs. Levels follow flag and enable with no extra delay,
  // so the controller sees a request drop in the cycle its cause goes away.

  always_comb begin
    for (int i = 0; i < tie_pkg::NCH; i++) begin
      cc_a_irq_o[i]      = st.flg[i][tie_pkg::FLG_A]   & st.ien[i][tie_pkg::EN_A];
      cc_b_irq_o[i]      = st.flg[i][tie_pkg::FLG_B]   & st.ien[i][tie_pkg::EN_B];
      cc_c_irq_o[i]      = st.flg[i][tie_pkg::FLG_C]   & st.ien[i][tie_pkg::EN_C];
      cc_d_irq_o[i]      = st.flg[i][tie_pkg::FLG_D]   & st.ien[i][tie_pkg::EN_D];
      overflow_irq_o[i]  = st.flg[i][tie_pkg::FLG_OVF] & st.ien[i][tie_pkg::EN_OVF];
      underflow_irq_o[i] = st.flg[i][tie_pkg::FLG_UNF] & st.ien[i][tie_pkg::EN_UNF];
      adc_start_a_o[i]   = cc_evt_i[i][tie_pkg::FLG_A] & st.ien[i][tie_pkg::EN_TRGA];
    end
  end

  assign cmp_e_irq_o        = st.flg_x[tie_pkg::EX_E] & st.ien_x[tie_pkg::EX_E];
  assign cmp_f_irq_o        = st.flg_x[tie_pkg::EX_F] & st.ien_x[tie_pkg::EX_F];
  assign adc_start_e_o      = ch0_cmp_e_evt_i & st.ien_x[tie_pkg::EX_TRGE];
  assign adc_start_trough_o = ch4_trough_i & cpwm_mode_i
                              & st.ien[tie_pkg::CH_OVF_TROUGH][tie_pkg::EN_TRGH];
  assign ch5_u_irq_o        = st.flg5[tie_pkg::C5_U] & st.ien5[tie_pkg::C5_U];
  assign ch5_v_irq_o        = st.flg5[tie_pkg::C5_V] & st.ien5[tie_pkg::C5_V];
  assign ch5_w_irq_o        = st.flg5[tie_pkg::C5_W] & st.ien5[tie_pkg::C5_W];

  // The clear strobe is combinational so the counter zeroes on the very edge
  // after the match, as a compare clear must.
  assign ch5_clear_o[tie_pkg::C5_U] = ch5_evt_i[tie_pkg::C5_U] & st.clr_ctl[tie_pkg::C5_U];
  assign ch5_clear_o[tie_pkg::C5_V] = ch5_evt_i[tie_pkg::C5_V] & st.clr_ctl[tie_pkg::C5_V];
  assign ch5_clear_o[tie_pkg::C5_W] = ch5_evt_i[tie_pkg::C5_W] & st.clr_ctl[tie_pkg::C5_W];

  assign reg_rdata_o = st.rdata;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_clr_u_on;
    reg_we_i && reg_addr_i == tie_pkg::OFS_CLR_CTL && reg_wdata_i[tie_pkg::C5_U];
  endsequence

  sequence s_clr_v_off;
    reg_we_i && reg_addr_i == tie_pkg::OFS_CLR_CTL && !reg_wdata_i[tie_pkg::C5_V];
  endsequence

  sequence s_quiet_evt_u;
    !reg_we_i && ch5_evt_i[tie_pkg::C5_U];
  endsequence

  a_clear_u_enabled: assert property (s_clr_u_on ##1 s_quiet_evt_u |-> ch5_clear_o[tie_pkg::C5_U])
    else $error("U counter clear missing after enable");

  a_clear_v_disabled: assert property (s_clr_v_off ##1 (!reg_we_i && ch5_evt_i[tie_pkg::C5_V])
                                       |-> !ch5_clear_o[tie_pkg::C5_V])
    else $error("V counter cleared while disabled");

  a_clear_w_follow: assert property (ch5_clear_o[tie_pkg::C5_W] |-> ch5_evt_i[tie_pkg::C5_W]
                                     && $past(reg_we_i) == 1'b0 |-> st.clr_ctl[tie_pkg::C5_W])
    else $error("W clear without enable");

  a_reserved_ch1_read: assert property (reg_re_i && reg_addr_i == tie_pkg::OFS_IEN0 + 4'h1
                                        |=> (reg_rdata_o & ~tie_pkg::IEN_WMASK[1]) == 8'h00)
    else $error("Reserved bits of channel 1 enable read nonzero");

  a_rdata_one_cycle: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("Read data present without a read");

  a_adc_a_gate: assert property (cc_evt_i[0][0] && !st.ien[0][tie_pkg::EN_TRGA] |-> !adc_start_a_o[0])
    else $error("ADC start raised with trigger disabled");

  a_trough_adc: assert property (reg_we_i && reg_addr_i == tie_pkg::OFS_IEN0 + 4'h4 && reg_wdata_i[tie_pkg::EN_TRGH]
                                 ##1 (!reg_we_i && ch4_trough_i && cpwm_mode_i) |-> adc_start_trough_o)
    else $error("Trough ADC start missing");

  a_unf_ch0_never: assert property (!underflow_irq_o[0] && !underflow_irq_o[3] && !underflow_irq_o[4])
    else $error("Underflow request on a channel without underflow");

  a_flag_a_irq: assert property (cc_evt_i[2][0] && st.ien[2][tie_pkg::EN_A] && !reg_we_i
                                 |=> cc_a_irq_o[2] && st.flg[2][tie_pkg::FLG_A])
    else $error("Channel 2 A request not raised after event");

  a_ovf_trough: assert property (ch4_trough_i && cpwm_mode_i |=> st.flg[4][tie_pkg::FLG_OVF])
    else $error("Channel 4 overflow flag not set at trough");

  a_unf_phase: assert property (unf_evt_i[1] && !phase_cnt_i[1] && !st.flg[1][tie_pkg::FLG_UNF]
                                |=> !st.flg[1][tie_pkg::FLG_UNF])
    else $error("Underflow flag set outside phase counting");

  a_set_beats_clear: assert property (cc_evt_i[3][1] && ch_flag_clr_i[3][tie_pkg::FLG_B]
                                      |=> st.flg[3][tie_pkg::FLG_B])
    else $error("Flag lost on simultaneous set and clear");

  a_irq_drops: assert property ($fell(st.flg[0][tie_pkg::FLG_OVF]) |-> !overflow_irq_o[0])
    else $error("Overflow request stayed after flag cleared");

  a_ch5_u_irq: assert property (ch5_evt_i[tie_pkg::C5_U] && st.ien5[tie_pkg::C5_U] && !reg_we_i
                                |=> ch5_u_irq_o)
    else $error("Channel 5 U request missing");

  a_cmp_e_irq: assert property (ch0_cmp_e_evt_i && st.ien_x[tie_pkg::EX_E] && !reg_we_i |=> cmp_e_irq_o)
    else $error("Compare E request missing");

  ////////////////////////////////////////////////////////////////////////////////
  // Per-channel checks. A clear with no set in the same cycle must take the
  // request down one cycle later, otherwise the controller would re-enter.

  for (genvar g = 0; g < tie_pkg::NCH; g++) begin : g_chan_chk

    a_irq_a_drop: assert property (ch_flag_clr_i[g][tie_pkg::FLG_A]
                                   && !cc_evt_i[g][tie_pkg::FLG_A]
                                   |=> !cc_a_irq_o[g])
      else $error("A request stayed after its flag clear");

    a_irq_b_drop: assert property (ch_flag_clr_i[g][tie_pkg::FLG_B]
                                   && !cc_evt_i[g][tie_pkg::FLG_B]
                                   |=> !cc_b_irq_o[g])
      else $error("B request stayed after its flag clear");

    a_b_flag_set: assert property (cc_evt_i[g][tie_pkg::FLG_B]
                                   |=> st.flg[g][tie_pkg::FLG_B])
      else $error("B flag not set after event");

    a_ovf_flag_set: assert property (wrap_evt_i[g]
                                     |=> st.flg[g][tie_pkg::FLG_OVF])
      else $error("Overflow flag not set after wrap");

    a_ovf_gate: assert property (!st.ien[g][tie_pkg::EN_OVF]
                                 |-> !overflow_irq_o[g])
      else $error("Overflow request raised while disabled");

    a_adc_a_cause: assert property (adc_start_a_o[g]
                                    |-> cc_evt_i[g][tie_pkg::FLG_A])
      else $error("ADC start without an A event");

    a_en_a_off: assert property (reg_we_i && reg_addr_i == tie_pkg::OFS_IEN0 + 4'(g)
                                 && !reg_wdata_i[tie_pkg::EN_A]
                                 |=> !cc_a_irq_o[g])
      else $error("A request stayed after its enable cleared");

  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on channel-specific requests and the reserved positions.

  a_cd_absent: assert property (!cc_c_irq_o[1] && !cc_c_irq_o[2]
                                && !cc_d_irq_o[1] && !cc_d_irq_o[2])
    else $error("C or D request on a channel without that flag");

  a_d_irq_ch3: assert property (cc_evt_i[3][tie_pkg::FLG_D] && st.ien[3][tie_pkg::EN_D]
                                && !reg_we_i |=> cc_d_irq_o[3])
    else $error("Channel 3 D request missing");

  a_c_irq_ch0: assert property (cc_evt_i[0][tie_pkg::FLG_C] && st.ien[0][tie_pkg::EN_C]
                                && !reg_we_i |=> cc_c_irq_o[0])
    else $error("Channel 0 C request missing");

  a_unf_irq_ch2: assert property (unf_evt_i[2] && phase_cnt_i[2]
                                  && st.ien[2][tie_pkg::EN_UNF] && !reg_we_i
                                  |=> underflow_irq_o[2])
    else $error("Channel 2 underflow request missing");

  a_adc_e_cause: assert property (adc_start_e_o
                                  |-> ch0_cmp_e_evt_i && st.ien_x[tie_pkg::EX_TRGE])
    else $error("ADC start on E without event or enable");

  a_cmp_f_irq: assert property (ch0_cmp_f_evt_i && st.ien_x[tie_pkg::EX_F]
                                && !reg_we_i |=> cmp_f_irq_o)
    else $error("Compare F request missing");

  a_cmp_f_drop: assert property (x_flag_clr_i[tie_pkg::EX_F] && !ch0_cmp_f_evt_i
                                 |=> !cmp_f_irq_o)
    else $error("Compare F request stayed after clear");

  a_ch5_v_irq: assert property (ch5_evt_i[tie_pkg::C5_V] && st.ien5[tie_pkg::C5_V]
                                && !reg_we_i |=> ch5_v_irq_o)
    else $error("Channel 5 V request missing");

  a_ch5_w_irq: assert property (ch5_evt_i[tie_pkg::C5_W] && st.ien5[tie_pkg::C5_W]
                                && !reg_we_i |=> ch5_w_irq_o)
    else $error("Channel 5 W request missing");

  a_ch5_u_drop: assert property (ch5_flag_clr_i[tie_pkg::C5_U] && !ch5_evt_i[tie_pkg::C5_U]
                                 |=> !ch5_u_irq_o)
    else $error("Channel 5 U request stayed after clear");

  a_trough_mode: assert property (adc_start_trough_o
                                  |-> cpwm_mode_i && ch4_trough_i)
    else $error("Trough ADC start outside complementary mode");

  a_clear_w_off: assert property (reg_we_i && reg_addr_i == tie_pkg::OFS_CLR_CTL
                                  && !reg_wdata_i[tie_pkg::C5_W]
                                  ##1 (!reg_we_i && ch5_evt_i[tie_pkg::C5_W])
                                  |-> !ch5_clear_o[tie_pkg::C5_W])
    else $error("W counter cleared while disabled");

  a_clear_v_on: assert property (reg_we_i && reg_addr_i == tie_pkg::OFS_CLR_CTL
                                 && reg_wdata_i[tie_pkg::C5_V]
                                 ##1 (!reg_we_i && ch5_evt_i[tie_pkg::C5_V])
                                 |-> ch5_clear_o[tie_pkg::C5_V])
    else $error("V counter clear missing after enable");

  a_clear_u_cause: assert property (ch5_clear_o[tie_pkg::C5_U]
                                    |-> ch5_evt_i[tie_pkg::C5_U])
    else $error("U counter cleared without an event");

  a_rsv_clr_read: assert property (reg_re_i && reg_addr_i == tie_pkg::OFS_CLR_CTL
                                   |=> reg_rdata_o[7:3] == 5'h00)
    else $error("Reserved bits of compare clear read nonzero");

  a_rsv_x_read: assert property (reg_re_i && reg_addr_i == tie_pkg::OFS_IEN_X
                                 |=> reg_rdata_o[6:2] == 5'h00)
    else $error("Reserved bits of extra enable read nonzero");

  a_rsv_ch5_read: assert property (reg_re_i && reg_addr_i == tie_pkg::OFS_IEN5
                                   |=> reg_rdata_o[7:3] == 5'h00)
    else $error("Reserved bits of channel 5 enable read nonzero");

  a_rsv_ch0_read: assert property (reg_re_i && reg_addr_i == tie_pkg::OFS_IEN0
                                   |=> (reg_rdata_o & ~tie_pkg::IEN_WMASK[0]) == 8'h00)
    else $error("Reserved bits of channel 0 enable read nonzero");

endmodule : tie_timer_irq_enable

// ---- verif/tie_req_sink.sv ----
// Model of the interrupt controller and converter trigger input facing the block.
`timescale 1ns/100ps

module tie_req_sink (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [34:0] irq_i,
  input  wire logic [6:0]  adc_i,
  output logic      [34:0] pend_o,
  output logic      [15:0] adc_cnt_o
);
  // Requests are levels and are only sampled; every start pulse is counted, so one held too long shows up.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pend_o    <= '0;
      adc_cnt_o <= '0;
    end else begin
      pend_o    <= irq_i;
      adc_cnt_o <= adc_cnt_o + 16'($countones(adc_i));
    end
  end
endmodule : tie_req_sink

// ---- verif/tie_bench.sv ----
// Self-checking bench for the timer request-enable and compare-clear block.
`timescale 1ns/100ps

module timer_irq_enable_and_compare_clear_test;
  logic                  clk_i, rst_n_i, reg_we_i, reg_re_i, ch4_trough_i, cpwm_mode_i;
  logic                  ch0_cmp_e_evt_i, ch0_cmp_f_evt_i, re_q;
  logic                  cmp_e_irq_o, cmp_f_irq_o, ch5_u_irq_o, ch5_v_irq_o, ch5_w_irq_o;
  logic                  adc_start_trough_o, adc_start_e_o;
  logic [3:0]            reg_addr_i;
  logic [7:0]            reg_wdata_i, reg_rdata_o;
  logic [4:0][3:0]       cc_evt_i;
  logic [4:0]            wrap_evt_i, unf_evt_i, phase_cnt_i, adc_start_a_o;
  logic [4:0]            cc_a_irq_o, cc_b_irq_o, cc_c_irq_o, cc_d_irq_o, overflow_irq_o, underflow_irq_o;
  logic [4:0][5:0]       ch_flag_clr_i;
  logic [1:0]            x_flag_clr_i;
  logic [2:0]            ch5_evt_i, ch5_flag_clr_i, ch5_clear_o;
  logic [34:0]           pend;
  logic [15:0]           adc_cnt;
  logic [7:0]            rd_q[$];
  logic [7:0]            en[8];
  int                    fails, check_count, adc_exp;
  localparam logic [7:0] MASK[8] = '{8'h07, 8'h9f, 8'hb3, 8'hb3, 8'h9f, 8'hdf, 8'h83, 8'h07};

  tie_timer_irq_enable uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o), .cc_evt_i(cc_evt_i),
    .wrap_evt_i(wrap_evt_i), .unf_evt_i(unf_evt_i), .phase_cnt_i(phase_cnt_i), .ch4_trough_i(ch4_trough_i),
    .cpwm_mode_i(cpwm_mode_i), .ch0_cmp_e_evt_i(ch0_cmp_e_evt_i), .ch0_cmp_f_evt_i(ch0_cmp_f_evt_i),
    .ch5_evt_i(ch5_evt_i), .ch_flag_clr_i(ch_flag_clr_i), .x_flag_clr_i(x_flag_clr_i),
    .ch5_flag_clr_i(ch5_flag_clr_i), .cc_a_irq_o(cc_a_irq_o), .cc_b_irq_o(cc_b_irq_o), .cc_c_irq_o(cc_c_irq_o),
    .cc_d_irq_o(cc_d_irq_o), .overflow_irq_o(overflow_irq_o), .underflow_irq_o(underflow_irq_o),
    .cmp_e_irq_o(cmp_e_irq_o), .cmp_f_irq_o(cmp_f_irq_o), .ch5_u_irq_o(ch5_u_irq_o), .ch5_v_irq_o(ch5_v_irq_o),
    .ch5_w_irq_o(ch5_w_irq_o), .adc_start_a_o(adc_start_a_o), .adc_start_trough_o(adc_start_trough_o),
    .adc_start_e_o(adc_start_e_o), .ch5_clear_o(ch5_clear_o));

  tie_req_sink sink (.clk_i(clk_i), .rst_n_i(rst_n_i), .pend_o(pend), .adc_cnt_o(adc_cnt),
    .irq_i({cc_a_irq_o, cc_b_irq_o, cc_c_irq_o, cc_d_irq_o, overflow_irq_o, underflow_irq_o,
            cmp_e_irq_o, cmp_f_irq_o, ch5_u_irq_o, ch5_v_irq_o, ch5_w_irq_o}),
    .adc_i({adc_start_a_o, adc_start_trough_o, adc_start_e_o}));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(string what, logic [34:0] exp, logic [34:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk_i);
    reg_we_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i    <= 1'b0;
  endtask : wr

  // The expected byte is queued here; the watcher below takes it when the data stand.
  task automatic rd(logic [3:0] a, logic [7:0] e);
    rd_q.push_back(e);
    @(posedge clk_i);
    reg_re_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i   <= 1'b0;
  endtask : rd

  always @(posedge clk_i) re_q <= reg_re_i;
  always @(negedge clk_i) if (re_q) chk("reg_rdata_o", 35'(rd_q.pop_front()), 35'(reg_rdata_o));

  task automatic chk_irq(logic [4:0][5:0] ir, logic [4:0] x);
    logic [34:0] ex;
    ex = 35'(x);
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 6; b++) ex[30 - 5 * b + i] = ir[i][b];
      chk("channel request", 35'(ir[i]), 35'({underflow_irq_o[i], overflow_irq_o[i], cc_d_irq_o[i],
          cc_c_irq_o[i], cc_b_irq_o[i], cc_a_irq_o[i]}));
    end
    chk("extra request", 35'(x), 35'({cmp_e_irq_o, cmp_f_irq_o, ch5_u_irq_o, ch5_v_irq_o, ch5_w_irq_o}));
    @(negedge clk_i);
    chk("pending", ex, pend);
  endtask : chk_irq

  task automatic flag_clear(logic v);
    @(posedge clk_i);
    ch_flag_clr_i  <= {30{v}};
    x_flag_clr_i   <= {2{v}};
    ch5_flag_clr_i <= {3{v}};
  endtask : flag_clear

  ////////////////////////////////////////////////////////////////////////////////
  task automatic round();
    logic [4:0][3:0] cc;
    logic [4:0]      wv, unf, a;
    logic [4:0][5:0] fl, ir;
    logic [7:0]      raw;
    logic [2:0]      c5;
    logic            cp;
    for (int i = 0; i < 8; i++) begin
      raw   = 8'($urandom);
      en[i] = raw & MASK[i];
      wr(4'(i), raw);
      rd(4'(i), en[i]);
    end
    cc  = 20'($urandom);
    wv  = 5'($urandom);
    unf = 5'($urandom);
    c5  = 3'($urandom);
    cp  = 1'($urandom);
    @(posedge clk_i);
    {cc_evt_i, wrap_evt_i, unf_evt_i, ch5_evt_i, cpwm_mode_i} <= {cc, wv, unf, c5, cp};
    {phase_cnt_i, ch4_trough_i, ch0_cmp_e_evt_i, ch0_cmp_f_evt_i} <= {5'($urandom), 3'b111};
    {ch_flag_clr_i, x_flag_clr_i, ch5_flag_clr_i} <= 35'({$urandom, $urandom});
    @(negedge clk_i);
    for (int i = 0; i < 5; i++) begin
      a[i]  = cc[i][0] & en[i+1][7];
      fl[i] = {unf[i] & phase_cnt_i[i] & (i == 1 || i == 2), wv[i] | (i == 4 && cp),
               cc[i] & ((i == 1 || i == 2) ? 4'h3 : 4'hf)};
      ir[i] = fl[i] & en[i+1][5:0];
    end
    chk("adc_start_a_o", 35'(a), 35'(adc_start_a_o));
    chk("adc_start_trough_o", 35'(cp & en[5][6]), 35'(adc_start_trough_o));
    chk("adc_start_e_o", 35'(en[6][7]), 35'(adc_start_e_o));
    chk("ch5_clear_o", 35'(c5 & en[0][2:0]), 35'(ch5_clear_o));
    adc_exp += $countones({a, cp & en[5][6], en[6][7]});
    @(posedge clk_i);
    {cc_evt_i, wrap_evt_i, unf_evt_i, ch5_evt_i, ch4_trough_i, ch0_cmp_e_evt_i, ch0_cmp_f_evt_i} <= '0;
    {ch_flag_clr_i, x_flag_clr_i, ch5_flag_clr_i} <= '0;
    @(negedge clk_i);
    chk_irq(ir, {en[6][0], en[6][1], c5 & en[7][2:0]});
    for (int i = 0; i < 5; i++) rd(4'(i + 8), {2'b00, fl[i]});
    rd(4'hd, 8'h03);
    rd(4'he, {5'h00, c5});
    for (int i = 1; i < 8; i++) wr(4'(i), 8'h00);
    @(negedge clk_i);
    chk_irq('0, 5'h00);
    flag_clear(1'b1);
    flag_clear(1'b0);
    for (int i = 1; i < 8; i++) wr(4'(i), en[i]);
    @(negedge clk_i);
    chk_irq('0, 5'h00);
  endtask : round

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    summarize();
  end

  initial begin
    {rst_n_i, reg_we_i, reg_re_i, reg_addr_i, reg_wdata_i, cc_evt_i, wrap_evt_i, unf_evt_i} = '0;
    {phase_cnt_i, ch4_trough_i, cpwm_mode_i, ch0_cmp_e_evt_i, ch0_cmp_f_evt_i, ch5_evt_i} = '0;
    {ch_flag_clr_i, x_flag_clr_i, ch5_flag_clr_i} = '0;
    void'($urandom(32'heff59a75));
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 16; i++) rd(4'(i), 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'h00);
    repeat (6) round();
    chk("adc count", 35'(adc_exp), 35'(adc_cnt));
    // A second reset in mid-run must bring every enable back to zero.
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 8; i++) rd(4'(i), 8'h00);
    repeat (2) @(negedge clk_i);
    summarize();
  end
endmodule : timer_irq_enable_and_compare_clear_test
